// *** verilog/at_bus_command_controller.sv ***
// bus command controller: processor status in, system strobes out
// assumes status lines come from pins, synchronised here; the reference
// crystal clock is sampled as a pin at clk_sys
`timescale 1ns/10ps
module at_bus_command_controller
  import bus_cmd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire cpu_status_type cpu_in,
  input wire logic inta_cycle,
  input wire logic refresh,
  input wire logic hold_ack,
  input wire logic low_byte_latch_control,
  input wire logic periph_crystal_in,
  input wire logic copro_select_in_n,
  input wire logic buffered_addr_bit_three,
  output cmd_type cmd_out,
  output cmd_type cmd_oe,
  output logic buffered_high_byte_en_n,
  output logic buffered_addr_bit_zero,
  output logic rtc_addr_strobe_en_n,
  output logic ref_clock_out,
  output logic ref_clock_div_twelve,
  output logic addr_latch_en,
  output logic row_strobe,
  output logic dt_r,
  output logic data_en,
  output logic low_lane_xcvr_en_n,
  output logic high_lane_xcvr_en_n,
  output logic copro_chip_select_out_n,
  output logic copro_reset,
  output logic cpu_reset
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  cpu_status_type st_s1_r, st_s2_r, st_s3_r, st_r;
  logic [2:0] osc_sync_r;
  logic osc_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_s1_r <= '{mem_io: 1'b0, st1_n: 1'b1, st0_n: 1'b1,
                   a1: 1'b0, a0: 1'b0, bhe_n: 1'b1};
      st_s2_r <= '{mem_io: 1'b0, st1_n: 1'b1, st0_n: 1'b1,
                   a1: 1'b0, a0: 1'b0, bhe_n: 1'b1};
      st_s3_r <= '{mem_io: 1'b0, st1_n: 1'b1, st0_n: 1'b1,
                   a1: 1'b0, a0: 1'b0, bhe_n: 1'b1};
      st_r <= '{mem_io: 1'b0, st1_n: 1'b1, st0_n: 1'b1,
                a1: 1'b0, a0: 1'b0, bhe_n: 1'b1};
    end else begin
      st_s1_r <= cpu_in;
      st_s2_r <= st_s1_r;
      st_s3_r <= st_s2_r;
      // accept a change only once two stages agree
      if (st_s2_r == st_s3_r) begin
        st_r <= st_s3_r;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      osc_sync_r <= 3'h0;
      osc_r <= 1'b0;
    end else begin
      osc_sync_r <= {osc_sync_r[1:0], periph_crystal_in};
      if (osc_sync_r[2] == osc_sync_r[1]) begin
        osc_r <= osc_sync_r[2];
      end
    end
  end

  // ------------------------------------------------------------
  // reference clocks
  // ------------------------------------------------------------
  logic osc_prev_r;
  logic [3:0] div_cnt_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      osc_prev_r <= 1'b0;
      ref_clock_out <= 1'b0;
    end else begin
      osc_prev_r <= osc_r;
      ref_clock_out <= osc_r;
    end
  end

  // toggle every six rising edges gives one twelfth of the input rate
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div_cnt_r <= 4'h0;
      ref_clock_div_twelve <= 1'b0;
    end else if (osc_r && !osc_prev_r) begin
      if (div_cnt_r == REF_HALF_M1) begin
        div_cnt_r <= 4'h0;
        ref_clock_div_twelve <= ~ref_clock_div_twelve;
      end else begin
        div_cnt_r <= div_cnt_r + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // cycle sequencer
  // ------------------------------------------------------------
  logic [1:0] st_code;
  logic cyc_start, is_halt, is_write, is_mem;
  phase_type phase_r;
  logic cyc_write_r, cyc_mem_r, cyc_inta_r;

  assign st_code = {st_r.st1_n, st_r.st0_n};
  // a new status leaving idle opens a cycle
  assign cyc_start = (st_code != ST_IDLE) && (phase_r == PH_IDLE);
  assign is_halt = (st_code == ST_HALT);
  assign is_write = (st_code == ST_WRITE);
  assign is_mem = st_r.mem_io;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      phase_r <= PH_IDLE;
    end else begin
      unique case (phase_r)
        PH_IDLE: begin
          if (cyc_start && !is_halt) begin
            phase_r <= PH_ADDR;
          end
        end
        PH_ADDR: begin
          phase_r <= PH_DATA;
        end
        PH_DATA: begin
          if (st_code == ST_IDLE) begin
            phase_r <= PH_TURN;
          end
        end
        PH_TURN: begin
          phase_r <= PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cyc_write_r <= 1'b1;
      cyc_mem_r <= 1'b0;
      cyc_inta_r <= 1'b0;
    end else if (phase_r == PH_IDLE && cyc_start && !is_halt) begin
      cyc_write_r <= is_write;
      cyc_mem_r <= is_mem;
      cyc_inta_r <= inta_cycle;
    end
  end

  // ------------------------------------------------------------
  // strobes and latch timing
  // ------------------------------------------------------------
  logic data_ph;
  assign data_ph = (phase_r == PH_DATA);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      addr_latch_en <= 1'b0;
      row_strobe <= 1'b0;
      rtc_addr_strobe_en_n <= 1'b1;
      cpu_reset <= 1'b0;
    end else begin
      // one pulse per cycle start, none for halt
      addr_latch_en <= cyc_start && !is_halt;
      row_strobe <= (cyc_start && !is_halt && is_mem) ||
                    (row_strobe && phase_r != PH_TURN);
      if (cyc_start && st_code == ST_READ) begin
        rtc_addr_strobe_en_n <= 1'b0;
      end
      cpu_reset <= !st_r.mem_io && is_halt && !st_r.a1;
    end
  end

  cmd_type cmd_nxt;
  always_comb begin
    cmd_nxt = '1;
    if (data_ph) begin
      if (cyc_inta_r) begin
        cmd_nxt.inta_n = 1'b0;
      end else if (cyc_mem_r) begin
        cmd_nxt.memr_n = cyc_write_r;
        cmd_nxt.memw_n = !cyc_write_r;
      end else begin
        cmd_nxt.ior_n = cyc_write_r;
        cmd_nxt.iow_n = !cyc_write_r;
      end
    end
    if (refresh) begin
      cmd_nxt.memr_n = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cmd_out <= '1;
      cmd_oe <= '1;
    end else begin
      cmd_out <= cmd_nxt;
      cmd_oe <= {5{!(hold_ack && !low_byte_latch_control)}};
    end
  end

  // ------------------------------------------------------------
  // data transceiver control
  // ------------------------------------------------------------
  logic copro_sel;
  assign copro_sel = !copro_select_in_n && buffered_addr_bit_three;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dt_r <= 1'b1;
      data_en <= 1'b0;
    end else begin
      // direction only moves in idle or address phase with enable off
      if (phase_r == PH_ADDR) begin
        dt_r <= cyc_write_r;
      end else if (phase_r == PH_IDLE) begin
        dt_r <= 1'b1;
      end
      data_en <= data_ph && (st_code != ST_IDLE);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      low_lane_xcvr_en_n <= 1'b1;
      high_lane_xcvr_en_n <= 1'b1;
      buffered_high_byte_en_n <= 1'b1;
      buffered_addr_bit_zero <= 1'b0;
      copro_chip_select_out_n <= 1'b1;
      copro_reset <= 1'b0;
    end else begin
      low_lane_xcvr_en_n <= !(data_en && !st_r.a0 && !copro_sel);
      high_lane_xcvr_en_n <= !(data_en && !st_r.bhe_n && !copro_sel);
      buffered_high_byte_en_n <= st_r.bhe_n;
      buffered_addr_bit_zero <= st_r.a0;
      copro_chip_select_out_n <= !copro_sel;
      copro_reset <= !copro_select_in_n && !buffered_addr_bit_three
                     && cyc_write_r && data_ph;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence halt_seen_s;
    cyc_start && is_halt;
  endsequence

  no_halt_ale_a: assert property (@(posedge clk_sys) disable iff (reset)
    halt_seen_s |=> !addr_latch_en) else $error("latch pulse on halt");
  float_cmds_a: assert property (@(posedge clk_sys) disable iff (reset)
    hold_ack && !low_byte_latch_control |=> cmd_oe == '0)
    else $error("commands driven in hold");
  den_dir_a: assert property (@(posedge clk_sys) disable iff (reset)
    $changed(dt_r) |-> !data_en) else $error("enable on at turn");
  idle_dir_a: assert property (@(posedge clk_sys) disable iff (reset)
    phase_r == PH_IDLE |=> dt_r) else $error("direction low when idle");
  lane_den_a: assert property (@(posedge clk_sys) disable iff (reset)
    !low_lane_xcvr_en_n || !high_lane_xcvr_en_n |-> $past(data_en))
    else $error("lane enable without data enable");
  copro_block_a: assert property (@(posedge clk_sys) disable iff (reset)
    copro_sel |=> low_lane_xcvr_en_n && high_lane_xcvr_en_n)
    else $error("lane open under coprocessor select");
  rtc_first_a: assert property (@(posedge clk_sys) disable iff (reset)
    cyc_start && st_code == ST_READ |=> !rtc_addr_strobe_en_n)
    else $error("address strobe enable missed");
  shutdown_a: assert property (@(posedge clk_sys) disable iff (reset)
    !st_r.mem_io && is_halt && !st_r.a1 |=> cpu_reset)
    else $error("shutdown reset missed");
  refresh_rd_a: assert property (@(posedge clk_sys) disable iff (reset)
    refresh |=> !cmd_out.memr_n) else $error("refresh without read");
  row_mem_a: assert property (@(posedge clk_sys) disable iff (reset)
    cyc_start && !is_halt && is_mem |=> row_strobe)
    else $error("row strobe missed");
  div_range_a: assert property (@(posedge clk_sys) disable iff (reset)
    div_cnt_r <= REF_HALF_M1) else $error("divider out of range");
endmodule

// *** verilog/bus_cmd_pkg.sv ***
// shared constants and carrier types for the bus command controller
// assumes a single 25 MHz system clock and synchronous active-high reset
package bus_cmd_pkg;
  // divide ratio of the peripheral reference clock
  localparam int REF_DIV = 12;
  localparam int REF_HALF = REF_DIV / 2;
  localparam logic [3:0] REF_HALF_M1 = 4'(REF_HALF - 1);
  // status pair encodings (status one, status zero)
  localparam logic [1:0] ST_IDLE = 2'h3;
  localparam logic [1:0] ST_READ = 2'h1;
  localparam logic [1:0] ST_WRITE = 2'h2;
  localparam logic [1:0] ST_HALT = 2'h0;
  // address bit positions in the captured cycle
  localparam int XA3_POS = 3;

  typedef enum logic [3:0] {
    PH_IDLE = 4'h1,
    PH_ADDR = 4'h2,
    PH_DATA = 4'h4,
    PH_TURN = 4'h8
  } phase_type;

  typedef struct packed {
    logic mem_io;
    logic st1_n;
    logic st0_n;
    logic a1;
    logic a0;
    logic bhe_n;
  } cpu_status_type;

  typedef struct packed {
    logic inta_n;
    logic ior_n;
    logic iow_n;
    logic memr_n;
    logic memw_n;
  } cmd_type;
endpackage

// *** tb/cpu_side_model.sv ***
// processor side model: drives the status and address pins for one cycle
// assumes start is raised by the bench at a clock edge
`timescale 1ns/10ps
module cpu_side_model
  import bus_cmd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic start,
  input wire cpu_status_type req,
  input wire logic [3:0] hold_len,
  output cpu_status_type cpu_in,
  output logic busy
);
  // ----------------------------------------
  // cycle sequencing
  // ----------------------------------------
  logic [3:0] cnt_r;
  logic act_r;
  initial begin
    cpu_in = 6'h1F;
    busy = 1'b0;
    act_r = 1'b0;
    cnt_r = 4'h0;
  end
  always @(posedge clk_sys) begin
    if (!busy && start) begin
      cpu_in <= req;
      cnt_r <= hold_len;
      busy <= 1'b1;
      act_r <= 1'b1;
    end else if (busy && cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else if (busy && act_r) begin
      // released address lines show the inverse, not the last value
      cpu_in <= {cpu_in.mem_io, 2'b11, ~cpu_in.a1, ~cpu_in.a0, ~cpu_in.bhe_n};
      act_r <= 1'b0;
      cnt_r <= 4'h6;
    end else begin
      busy <= 1'b0;
    end
  end
endmodule

// *** tb/test_at_bus_command_controller.sv ***
// bench for the bus command controller
// assumes the processor side model owns the status pins
`timescale 1ns/10ps
module test_at_bus_command_controller import bus_cmd_pkg::*; ;
  typedef struct packed {
    cpu_status_type s;
    logic inta;
    logic [4:0] cmd;
    logic dtr;
    logic row;
  } row_type;
  row_type rows [5] = '{'{6'h28, 1'b0, 5'h1D, 1'b0, 1'b1},
    '{6'h32, 1'b0, 5'h1E, 1'b1, 1'b1}, '{6'h09, 1'b0, 5'h17, 1'b0, 1'b0},
    '{6'h14, 1'b0, 5'h1B, 1'b1, 1'b0}, '{6'h0C, 1'b1, 5'h0F, 1'b0, 1'b0}};
  logic clk_sys = 1'b0, reset = 1'b1, start = 1'b0, inta_cycle = 1'b0;
  logic refresh = 1'b0, hold_ack = 1'b0, low_byte_latch_control = 1'b1;
  logic periph_crystal_in = 1'b0, copro_select_in_n = 1'b1;
  logic buffered_addr_bit_three = 1'b0, busy, seen, rst_seen, run = 1'b0;
  cpu_status_type req = 6'h1F, cpu_in;
  cmd_type cmd_out, cmd_oe;
  logic buffered_high_byte_en_n, buffered_addr_bit_zero, rtc_addr_strobe_en_n;
  logic ref_clock_out, ref_clock_div_twelve, addr_latch_en, row_strobe, dt_r;
  logic data_en, low_lane_xcvr_en_n, high_lane_xcvr_en_n, copro_reset;
  logic copro_chip_select_out_n, cpu_reset, ref_prev, div_prev, dt_prev;
  logic den_prev, osc_half = 1'b0;
  int bad_count = 0, num_checks = 0, ref_cnt = 0, div_cnt = 0;
  int ref_per = 0, div_per = 0;
  at_bus_command_controller DUT (.clk_sys, .reset, .cpu_in, .inta_cycle,
    .refresh, .hold_ack, .low_byte_latch_control, .periph_crystal_in,
    .copro_select_in_n, .buffered_addr_bit_three, .cmd_out, .cmd_oe,
    .buffered_high_byte_en_n, .buffered_addr_bit_zero, .rtc_addr_strobe_en_n,
    .ref_clock_out, .ref_clock_div_twelve, .addr_latch_en, .row_strobe, .dt_r,
    .data_en, .low_lane_xcvr_en_n, .high_lane_xcvr_en_n,
    .copro_chip_select_out_n, .copro_reset, .cpu_reset);
  cpu_side_model partner (.clk_sys, .start, .req, .hold_len(4'hC), .cpu_in,
    .busy);
  always #20 clk_sys = ~clk_sys;
  // crystal at a quarter of clk_sys: a faster pin never settles in the sync
  always @(posedge clk_sys) begin
    osc_half <= ~osc_half;
    if (osc_half) periph_crystal_in <= ~periph_crystal_in;
  end
  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    num_checks++;
    if (got !== want) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic bus_cycle(input cpu_status_type s);
    seen = 1'b0;
    rst_seen = 1'b0;
    @(posedge clk_sys);
    req <= s;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    for (int i = 0; i < 14 && !seen; i++) begin
      @(posedge clk_sys);
      #1;
      seen = (addr_latch_en === 1'b1);
      rst_seen |= (cpu_reset === 1'b1);
    end
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic finish_cycle();
    int n = 0;
    while (busy !== 1'b0 && n < 30) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 30) begin
      bad_count++;
      print_verdict();
    end
    repeat (3) @(posedge clk_sys);
  endtask
  // pin periods and the enable guard on every direction change
  always @(posedge clk_sys) begin
    ref_prev <= ref_clock_out;
    div_prev <= ref_clock_div_twelve;
    dt_prev <= dt_r;
    den_prev <= data_en;
    ref_cnt <= (ref_clock_out && !ref_prev) ? 1 : ref_cnt + 1;
    div_cnt <= (ref_clock_div_twelve && !div_prev) ? 1 : div_cnt + 1;
    if (ref_clock_out && !ref_prev) ref_per <= ref_cnt;
    if (ref_clock_div_twelve && !div_prev) div_per <= div_cnt;
    if (run && dt_r !== dt_prev) check(8'({data_en, den_prev}), 8'h00);
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    run <= 1'b1;
    @(posedge clk_sys);
    #1;
    check(8'(cmd_out), 8'h1F);
    check({cmd_oe, dt_r, data_en, rtc_addr_strobe_en_n}, 8'hFD);
    foreach (rows[i]) begin
      @(posedge clk_sys);
      inta_cycle <= rows[i].inta;
      bus_cycle(rows[i].s);
      if (!seen) check(8'h00, 8'h01);
      check(8'(cmd_out), 8'(rows[i].cmd));
      check({dt_r, data_en, row_strobe}, {rows[i].dtr, 1'b1, rows[i].row});
      check({low_lane_xcvr_en_n, high_lane_xcvr_en_n, buffered_high_byte_en_n,
        buffered_addr_bit_zero}, {rows[i].s.a0, rows[i].s.bhe_n,
        rows[i].s.bhe_n, rows[i].s.a0});
      finish_cycle();
      #1;
      check(8'(cmd_out), 8'h1F);
      check({dt_r, data_en, low_lane_xcvr_en_n, high_lane_xcvr_en_n}, 8'h0B);
    end
    check(8'(rtc_addr_strobe_en_n), 8'h00);
    @(posedge clk_sys);
    inta_cycle <= 1'b0;
    // address bit one decides between shutdown and a plain halt
    for (int k = 0; k < 2; k++) begin
      bus_cycle(k == 0 ? 6'h03 : 6'h07);
      check({seen, rst_seen}, k == 0 ? 8'h01 : 8'h00);
      finish_cycle();
    end
    refresh <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check(8'(cmd_out.memr_n), 8'h00);
    @(posedge clk_sys);
    refresh <= 1'b0;
    hold_ack <= 1'b1;
    low_byte_latch_control <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    check(8'(cmd_oe), 8'h00);
    @(posedge clk_sys);
    low_byte_latch_control <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check(8'(cmd_oe), 8'h1F);
    @(posedge clk_sys);
    hold_ack <= 1'b0;
    copro_select_in_n <= 1'b0;
    buffered_addr_bit_three <= 1'b1;
    bus_cycle(6'h28);
    check({copro_chip_select_out_n, low_lane_xcvr_en_n,
      high_lane_xcvr_en_n}, 8'h03);
    finish_cycle();
    // select low with bit three low on a write resets the coprocessor
    buffered_addr_bit_three <= 1'b0;
    bus_cycle(6'h32);
    check({copro_reset, copro_chip_select_out_n}, 8'h03);
    finish_cycle();
    #1;
    check(8'(copro_reset), 8'h00);
    check(8'(ref_per), 8'h04);
    check(8'(div_per), 8'h30);
    print_verdict();
  end
endmodule
